// ---- sctl_device.sv ----
// Device end: main control register with soft reset, sleep and calibration kicks.
// Assumes host drives one write per cycle on the same clock.
`timescale 1ns/1ps
module sctl_device (
  input  wire logic  clk,
  input  wire logic  rstn,
  sctl_if.device     bus,
  output logic       soft_reset,
  output logic       sleep,
  output logic       profile_select,
  output logic       dual_profile_cal_enable,
  output logic       cal_start,
  output logic       cal_both
);
  logic [15:0] ctrl_q, ctrl_d;
  logic [15:0] img_d;
  logic        srst_q, srst_d;
  logic        cal_q, cal_d;
  logic        both_q, both_d;
  logic        init_done_q, init_done_d;
  logic        recal_q, recal_d;
  logic        sleep_q, sleep_d;
  logic        hit;
  logic        cal_req;
  logic        recal_rise;

  // Address decode; only the main control word lives in this block
  always_comb
  begin
    hit = bus.wr_en && (bus.wr_addr == sctl_pkg::MAIN_CTRL_OFS);
  end

  // Per-bit write policy for the image
  // Reserved bits hold their fixed value so a careless host cannot disturb them
  for (genvar b = 0; b < sctl_pkg::DATA_W; b++)
  begin : g_img
    if (b == sctl_pkg::BIT_SOFT_RESET)
    begin : g_self_clr
      assign img_d[b] = 1'b0;
    end
    else if (sctl_pkg::WRITE_MASK[b])
    begin : g_rw
      assign img_d[b] = bus.wr_data[b];
    end
    else
    begin : g_fixed
      assign img_d[b] = sctl_pkg::FIXED_ONES[b];
    end
  end

  // Register image: soft reset wins over a write landing in the same cycle
  always_comb
  begin
    ctrl_d = ctrl_q;
    if (srst_q)
    begin
      ctrl_d = sctl_pkg::MAIN_CTRL_RST;
    end
    else if (hit)
    begin
      ctrl_d = img_d;
    end
  end

  // Image flops
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      ctrl_q <= sctl_pkg::MAIN_CTRL_RST;
    end
    else
    begin
      ctrl_q <= ctrl_d;
    end
  end

  // Soft reset strobe: one cycle only, the bit never sits in the image
  always_comb
  begin
    srst_d = 1'b0;
    if (!srst_q && hit)
    begin
      srst_d = bus.wr_data[sctl_pkg::BIT_SOFT_RESET];
    end
  end

  // Soft reset flop
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      srst_q <= 1'b0;
    end
    else
    begin
      srst_q <= srst_d;
    end
  end

  // Calibration kicks: one pulse per qualifying write
  // The recal bit is edge-sensitive, so a host that never clears it gets no second recal
  always_comb
  begin
    cal_d       = 1'b0;
    both_d      = both_q;
    init_done_d = init_done_q;
    recal_d     = recal_q;
    cal_req     = 1'b0;
    recal_rise  = 1'b0;
    if (srst_q)
    begin
      both_d      = 1'b0;
      init_done_d = 1'b0;
      recal_d     = 1'b0;
    end
    else if (hit)
    begin
      recal_d    = bus.wr_data[sctl_pkg::BIT_RECAL];
      cal_req    = bus.wr_data[sctl_pkg::BIT_CAL_EN] && !bus.wr_data[sctl_pkg::BIT_SOFT_RESET];
      recal_rise = bus.wr_data[sctl_pkg::BIT_RECAL] && !recal_q;
      if (cal_req)
      begin
        cal_d = 1'b1;
        if (!init_done_q)
        begin
          both_d      = bus.wr_data[sctl_pkg::BIT_DUAL_CAL];
          init_done_d = 1'b1;
        end
        else
        begin
          both_d = 1'b0;
        end
        if (recal_rise)
        begin
          both_d = 1'b1;
        end
      end
    end
  end

  // Calibration flops
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      cal_q       <= 1'b0;
      both_q      <= 1'b0;
      init_done_q <= 1'b0;
      recal_q     <= 1'b0;
    end
    else
    begin
      cal_q       <= cal_d;
      both_q      <= both_d;
      init_done_q <= init_done_d;
      recal_q     <= recal_d;
    end
  end

  // Sleep from the bit or from chip enable low; flopped from the next image, so it changes in the same cycle as the image
  always_comb
  begin
    sleep_d = ctrl_d[sctl_pkg::BIT_SLEEP] || !bus.chip_enable;
  end

  // Sleep flop
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      sleep_q <= 1'b0;
    end
    else
    begin
      sleep_q <= sleep_d;
    end
  end

  assign bus.rd_data             = ctrl_q;
  assign soft_reset              = srst_q;
  assign sleep                   = sleep_q;
  assign profile_select          = ctrl_q[sctl_pkg::BIT_PROF_SEL];
  assign dual_profile_cal_enable = ctrl_q[sctl_pkg::BIT_DUAL_CAL];
  assign cal_start               = cal_q;
  assign cal_both                = both_q;
endmodule

// ---- sctl_pkg.sv ----
// Package for the synthesizer main control register and its host driver.
// Assumes a single 200 MHz clock domain shared by both ends.
package sctl_pkg;
  localparam int          DATA_W          = 16;
  localparam int          ADDR_W          = 6;
  localparam logic [5:0]  MAIN_CTRL_OFS   = 6'h00;
  localparam logic [15:0] MAIN_CTRL_RST   = 16'h0003;
  localparam int          BIT_SOFT_RESET  = 13;
  localparam int          BIT_SLEEP       = 12;
  localparam int          BIT_RECAL       = 9;
  localparam int          BIT_DUAL_CAL    = 7;
  localparam int          BIT_PROF_SEL    = 6;
  localparam int          BIT_CAL_EN      = 0;
  localparam logic [15:0] WRITE_MASK      = 16'h32C1;
  localparam logic [15:0] FIXED_ONES      = 16'h0002;
  localparam int          CLK_MHZ         = 200;
  localparam int          WAKE_WAIT_US    = 100;
  localparam int          WAKE_WAIT_CYC   = WAKE_WAIT_US * CLK_MHZ;
endpackage

// ---- sctl_if.sv ----
// Interface joining host driver and control register.
// Assumes both ends share clk and rstn.
`timescale 1ns/1ps
interface sctl_if;
  logic                           wr_en;
  logic [sctl_pkg::ADDR_W-1:0]    wr_addr;
  logic [sctl_pkg::DATA_W-1:0]    wr_data;
  logic [sctl_pkg::DATA_W-1:0]    rd_data;
  logic                           chip_enable;

  modport device (input wr_en, input wr_addr, input wr_data, input chip_enable, output rd_data);
  modport host   (output wr_en, output wr_addr, output wr_data, output chip_enable, input rd_data);
endinterface

// ---- sctl_host.sv ----
// Host end: turns user requests into legal control register writes.
// Assumes the device end decodes writes on the same clock.
`timescale 1ns/1ps
module sctl_host #(
  parameter int WAKE_WAIT = sctl_pkg::WAKE_WAIT_CYC
) (
  input  wire logic  clk,
  input  wire logic  rstn,
  sctl_if.host       bus,
  input  wire logic  req_write,
  input  wire logic  req_sleep,
  input  wire logic  req_soft_reset,
  input  wire logic  req_recal,
  input  wire logic  req_dual_cal,
  input  wire logic  req_prof_sel,
  input  wire logic  req_cal_en,
  input  wire logic  req_chip_enable,
  output logic       busy
);
  typedef enum logic [2:0] {S_IDLE, S_WRITE, S_CLR_RECAL, S_WAKE_WAIT, S_WAKE_WRITE} sctl_hst_t;

  sctl_hst_t   st_q, st_d;
  logic [15:0] data_q, data_d;
  logic        wr_q, wr_d;
  logic        sleep_q, sleep_d;
  logic        ce_q, ce_d;
  logic [31:0] cnt_q, cnt_d;
  logic        busy_q;

  // Sequencer: wake wait, recal clear, write shaping
  always_comb
  begin
    st_d    = st_q;
    data_d  = data_q;
    wr_d    = 1'b0;
    sleep_d = sleep_q;
    ce_d    = req_chip_enable;
    cnt_d   = cnt_q;
    unique case (st_q)
      S_IDLE:
      begin
        if (ce_q == 1'b0 && req_chip_enable == 1'b1)
        begin
          cnt_d = 32'h0;
          st_d  = S_WAKE_WAIT;
        end
        else if (req_write)
        begin
          data_d = sctl_pkg::FIXED_ONES;
          data_d[sctl_pkg::BIT_SOFT_RESET] = req_soft_reset;
          data_d[sctl_pkg::BIT_SLEEP]      = req_sleep;
          data_d[sctl_pkg::BIT_RECAL]      = req_recal;
          data_d[sctl_pkg::BIT_DUAL_CAL]   = req_dual_cal;
          data_d[sctl_pkg::BIT_PROF_SEL]   = req_prof_sel;
          data_d[sctl_pkg::BIT_CAL_EN]     = req_cal_en;
          sleep_d = req_sleep;
          wr_d    = 1'b1;
          if (sleep_q && !req_sleep)
          begin
            cnt_d = 32'h0;
            st_d  = S_WAKE_WAIT;
          end
          else if (req_recal)
            st_d = S_CLR_RECAL;
          else
            st_d = S_WRITE;
        end
      end
      S_WRITE:
        st_d = S_IDLE;
      S_CLR_RECAL:
      begin
        data_d[sctl_pkg::BIT_RECAL] = 1'b0;
        wr_d = 1'b1;
        st_d = S_WRITE;
      end
      S_WAKE_WAIT:
      begin
        cnt_d = cnt_q + 32'h1;
        if (cnt_q >= 32'(WAKE_WAIT - 1))
          st_d = S_WAKE_WRITE;
      end
      S_WAKE_WRITE:
      begin
        data_d[sctl_pkg::BIT_SLEEP]  = 1'b0;
        data_d[sctl_pkg::BIT_RECAL]  = 1'b0;
        data_d[sctl_pkg::BIT_CAL_EN] = 1'b1;
        data_d[sctl_pkg::BIT_SOFT_RESET] = 1'b0;
        wr_d = 1'b1;
        st_d = S_WRITE;
      end
    endcase
  end

  // Register the sequencer
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      st_q    <= S_IDLE;
      data_q  <= sctl_pkg::MAIN_CTRL_RST;
      wr_q    <= 1'b0;
      sleep_q <= 1'b0;
      ce_q    <= 1'b1;
      cnt_q   <= 32'h0;
      busy_q  <= 1'b0;
    end
    else
    begin
      st_q    <= st_d;
      data_q  <= data_d;
      wr_q    <= wr_d;
      sleep_q <= sleep_d;
      ce_q    <= ce_d;
      cnt_q   <= cnt_d;
      busy_q  <= (st_d != S_IDLE); // Same timing as the state, but from a flop
    end
  end

  assign bus.wr_en       = wr_q;
  assign bus.wr_addr     = sctl_pkg::MAIN_CTRL_OFS;
  assign bus.wr_data     = data_q;
  assign bus.chip_enable = ce_q;
  assign busy            = busy_q;
endmodule

// ---- sctl_chk.sv ----
// Checker for the host to device control link.
// Assumes one clock; sees only the interface signals.
`timescale 1ns/1ps
module sctl_chk (
  input wire logic                        clk,
  input wire logic                        rstn,
  input wire logic                        wr_en,
  input wire logic [sctl_pkg::ADDR_W-1:0] wr_addr,
  input wire logic [sctl_pkg::DATA_W-1:0] wr_data,
  input wire logic [sctl_pkg::DATA_W-1:0] rd_data,
  input wire logic                        chip_enable
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // Register image after reset, writes and soft reset
  rst_value_a: assert property ($rose(rstn) |-> rd_data == 16'h0003)
    else $error("reset value wrong");
  write_image_a: assert property (wr_en && wr_addr == 6'h00 && !wr_data[13] |=>
    rd_data == (($past(wr_data) & 16'h32C1) | 16'h0002)) else $error("write image wrong");
  soft_rst_a: assert property (wr_en && wr_addr == 6'h00 && wr_data[13] |-> ##2
    rd_data == 16'h0003) else $error("soft reset missed");
  // Only bit 13 clears itself, so idle cycles keep the image
  idle_hold_a: assert property (!wr_en && !$past(wr_en) |=> $stable(rd_data))
    else $error("image changed idle");
  // Host side write discipline
  rsv_zero_a: assert property (wr_en |-> (wr_data & 16'hCD00) == 16'h0000)
    else $error("reserved bit set");
  rsv_one_a: assert property (wr_en |-> wr_data[5:1] == 5'h01)
    else $error("fixed field wrong");
  recal_clr_a: assert property (wr_en && wr_data[9] |=> ##[0:3] (wr_en && !wr_data[9]))
    else $error("recal not cleared");
  wake_wait_a: assert property ($rose(chip_enable) |-> !wr_en [*8])
    else $error("write too soon");
  wake_cal_a: assert property ($rose(chip_enable) |-> ##[1:40] (wr_en && wr_data[0]))
    else $error("no wake rewrite");
  cover property (wr_en && wr_data[13]);
  cover property (wr_en && wr_data[9]);
  cover property ($rose(chip_enable));
endmodule

// ---- test_synth_top_control_register.sv ----
// Bench driving the host user side against the device end.
// Assumes a 200 MHz clock and a short wake wait of 10.
`timescale 1ns/1ps
module test_synth_top_control_register;
  logic        clk, rstn, req_write, req_sleep, req_soft_reset, req_recal;
  logic        req_dual_cal, req_prof_sel, req_cal_en, req_chip_enable, busy;
  logic        soft_reset, sleep, prof, dual, cal_start, cal_both;
  logic [15:0] ncal, nboth, nsrst;
  int          errors, checks_done;
  sctl_if bus_if();
  sctl_host #(.WAKE_WAIT(10)) u_sctl_host (.clk(clk), .rstn(rstn), .bus(bus_if), .req_write(req_write),
    .req_sleep(req_sleep), .req_soft_reset(req_soft_reset), .req_recal(req_recal), .req_dual_cal(req_dual_cal),
    .req_prof_sel(req_prof_sel), .req_cal_en(req_cal_en), .req_chip_enable(req_chip_enable), .busy(busy));
  sctl_device u_sctl_device (.clk(clk), .rstn(rstn), .bus(bus_if), .soft_reset(soft_reset), .sleep(sleep),
    .profile_select(prof), .dual_profile_cal_enable(dual), .cal_start(cal_start), .cal_both(cal_both));
  sctl_chk u_sctl_chk (.clk(clk), .rstn(rstn), .wr_en(bus_if.wr_en), .wr_addr(bus_if.wr_addr),
    .wr_data(bus_if.wr_data), .rd_data(bus_if.rd_data), .chip_enable(bus_if.chip_enable));
  // Clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Count calibration kicks and soft resets; pulses last one cycle
  always @(posedge clk)
  begin
    if (cal_start) ncal <= ncal + 16'h0001;
    if (cal_start && cal_both) nboth <= nboth + 16'h0001;
    if (soft_reset) nsrst <= nsrst + 16'h0001;
  end
  task automatic chk(input string s, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %s exp %h seen %h", s, exp, seen);
    end
  endtask
  // One request: {sleep, soft reset, recal, dual, select, cal}
  task automatic wr(input logic [5:0] f);
    int n;
    @(negedge clk);
    {req_sleep, req_soft_reset, req_recal, req_dual_cal, req_prof_sel, req_cal_en} = f;
    req_write = 1'b1;
    @(negedge clk);
    req_write = 1'b0;
    n = 0;
    while (busy !== 1'b0 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    repeat (3) @(negedge clk);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog against a hung handshake
  initial
  begin
    #10000;
    errors++;
    tally_and_finish();
  end
  // Main sequence
  initial
  begin
    {rstn, req_write, req_sleep, req_soft_reset, req_recal, req_dual_cal, req_prof_sel, req_cal_en} = 8'h00;
    req_chip_enable = 1'b1;
    ncal = 16'h0000;
    nboth = 16'h0000;
    nsrst = 16'h0000;
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    chk("rd", bus_if.rd_data, 16'h0003);
    chk("sleep", {15'h0000, sleep}, 16'h0000);
    $display("t1 done");
    wr(6'h07);
    chk("rd", bus_if.rd_data, 16'h00C3);
    chk("prof", {15'h0000, prof}, 16'h0001);
    chk("dual", {15'h0000, dual}, 16'h0001);
    chk("ncal", ncal, 16'h0001);
    chk("nboth", nboth, 16'h0001);
    wr(6'h00);
    chk("rd", bus_if.rd_data, 16'h0002);
    chk("ncal", ncal, 16'h0001);
    wr(6'h09);
    chk("ncal", ncal, 16'h0003);
    chk("nboth", nboth, 16'h0002);
    chk("rd", bus_if.rd_data, 16'h0003);
    $display("t2 done");
    wr(6'h21);
    chk("rd", bus_if.rd_data, 16'h1003);
    chk("sleep", {15'h0000, sleep}, 16'h0001);
    wr(6'h01);
    chk("sleep", {15'h0000, sleep}, 16'h0000);
    chk("ncal", ncal, 16'h0006);
    req_chip_enable = 1'b0;
    repeat (3) @(negedge clk);
    chk("sleep", {15'h0000, sleep}, 16'h0001);
    req_chip_enable = 1'b1;
    repeat (30) @(negedge clk);
    chk("sleep", {15'h0000, sleep}, 16'h0000);
    chk("ncal", ncal, 16'h0007);
    $display("t3 done");
    wr(6'h07);
    wr(6'h10);
    chk("rd", bus_if.rd_data, 16'h0003);
    chk("prof", {15'h0000, prof}, 16'h0000);
    chk("dual", {15'h0000, dual}, 16'h0000);
    chk("nsrst", nsrst, 16'h0001);
    $display("t4 done");
    wr(6'h03);
    chk("rd", bus_if.rd_data, 16'h0043);
    chk("prof", {15'h0000, prof}, 16'h0001);
    chk("ncal", ncal, 16'h0009);
    chk("nboth", nboth, 16'h0002);
    $display("t5 done");
    tally_and_finish();
  end
endmodule
